// file: hdl/rtd_defs.svh
`ifndef RTD_DEFS_SVH
`define RTD_DEFS_SVH

// ==========================================================
// Register map, word addresses on the host port
`define RTD_ADDR_W          12
`define RTD_DATA_W          16
`define RTD_MEM_WORDS       4096
`define RTD_REG_MASTER_CFG  12'h000
`define RTD_REG_INT_STATUS  12'h001
`define RTD_REG_INT_ENABLE  12'h002
`define RTD_REG_INT_CLEAR   12'h003
`define RTD_CFG_RESET       16'h0000
`define RTD_CFG_START_BIT   4
`define RTD_CFG_SIMPLE_BIT  3

// ==========================================================
// Descriptor quadrants
`define RTD_TXSA_BASE       12'h480
`define RTD_RXMC_BASE       12'h500
`define RTD_TXMC_BASE       12'h580
`define RTD_DESC_CTRL       12'h000
`define RTD_DESC_PTR        12'h001
`define RTD_DESC_INDEX      12'h002
`define RTD_DESC_BCAST      12'h003
`define RTD_MC_DATA         12'h003
`define RTD_BUF_DATA_OFS    12'h002
`define RTD_BUF_WORDS       34
`define RTD_MAX_DATA_WORDS  6'd32
`define RTD_MC_SYNC_DATA    5'h11

// ==========================================================
// Control word interrupt options, status bits
`define RTD_CTRL_IWA_BIT    14
`define RTD_CTRL_SEC_BIT    13
`define RTD_NUM_EVENTS      4
`define RTD_EV_ACCESSED     0
`define RTD_EV_SECOND       1
`define RTD_EV_INDEX_ZERO   2
`define RTD_EV_IGNORED      3

`endif

// file: hdl/rtd_pkg.sv
package rtd_pkg;

   typedef enum logic [2:0] {
      RTD_IDLE,
      RTD_DESC,
      RTD_TX,
      RTD_RX,
      RTD_MC_RX,
      RTD_MIW,
      RTD_TTW,
      RTD_INDEX
   } rtd_state_t;

endpackage

// file: hdl/rtd_sticky_bit.sv
`timescale 1ns/100ps

// ==========================================================
// Sticky event flag, a set in the clearing cycle wins
module rtd_sticky_bit (
   input  wire logic core_clk_in,
   input  wire logic resetn_in,
   input  wire logic ce_in,
   input  wire logic set_in,
   input  wire logic clr_in,
   output logic      flag_out
);

   logic flag_reg;

   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         flag_reg <= 1'b0;
      end else if (ce_in) begin
         if (set_in) begin
            flag_reg <= 1'b1;
         end else if (clr_in) begin
            flag_reg <= 1'b0;
         end
      end
   end

   assign flag_out = flag_reg;

endmodule // rtd_sticky_bit

// file: hdl/rtd_desc_engine.sv
`timescale 1ns/100ps
`include "rtd_defs.svh"

module rtd_desc_engine
   import rtd_pkg::*;
(
   input  wire logic                   core_clk_in,
   input  wire logic                   resetn_in,
   input  wire logic                   ce_in,
   input  wire logic [`RTD_ADDR_W-1:0] reg_addr_in,
   input  wire logic [`RTD_DATA_W-1:0] reg_wdata_in,
   input  wire logic                   reg_wr_in,
   input  wire logic                   reg_rd_in,
   output logic      [`RTD_DATA_W-1:0] reg_rdata_out,
   input  wire logic                   cmd_valid_in,
   output logic                        cmd_ready_out,
   input  wire logic                   cmd_tx_in,
   input  wire logic                   cmd_bcast_in,
   input  wire logic [4:0]             cmd_sa_in,
   input  wire logic [4:0]             cmd_wc_in,
   input  wire logic                   rx_valid_in,
   output logic                        rx_ready_out,
   input  wire logic [`RTD_DATA_W-1:0] rx_data_in,
   output logic                        tx_valid_out,
   input  wire logic                   tx_ready_in,
   output logic      [`RTD_DATA_W-1:0] tx_data_out,
   output logic                        busy_out,
   output logic                        running_out,
   output logic                        irq_out
);

   // =======================================================
   // Storage and state
   logic [`RTD_DATA_W-1:0]    mem_q [0:`RTD_MEM_WORDS-1];
   logic [`RTD_DATA_W-1:0]    cfg_reg;
   logic [`RTD_NUM_EVENTS-1:0] ien_reg;
   logic [`RTD_NUM_EVENTS-1:0] status_w;
   logic [`RTD_NUM_EVENTS-1:0] event_w;
   logic [`RTD_NUM_EVENTS-1:0] clear_w;
   logic [`RTD_DATA_W-1:0]    rdata_reg;
   logic [`RTD_DATA_W-1:0]    ttag_reg;
   rtd_state_t                state_reg;
   logic                      cmd_tx_reg;
   logic                      cmd_bcast_reg;
   logic [4:0]                cmd_sa_reg;
   logic [4:0]                cmd_wc_reg;
   logic [`RTD_ADDR_W-1:0]    desc_reg;
   logic [`RTD_ADDR_W-1:0]    buf_reg;
   logic [`RTD_ADDR_W-1:0]    ptr_reg;
   logic [5:0]                cnt_reg;
   logic [`RTD_DATA_W-1:0]    ctrl_reg;
   logic [`RTD_DATA_W-1:0]    index_reg;
   logic                      tx_valid_reg;
   logic [`RTD_DATA_W-1:0]    tx_data_reg;
   logic                      eng_we;
   logic [`RTD_ADDR_W-1:0]    eng_addr;
   logic [`RTD_DATA_W-1:0]    eng_wdata;
   logic                      host_mem_wr;
   logic                      started;
   logic                      simple_mc;
   logic                      is_mc;
   logic [`RTD_ADDR_W-1:0]    desc_addr;
   logic [`RTD_ADDR_W-1:0]    sa_ptr;
   logic [5:0]                word_cnt;

   assign started     = cfg_reg[`RTD_CFG_START_BIT];
   assign simple_mc   = cfg_reg[`RTD_CFG_SIMPLE_BIT];
   assign host_mem_wr = reg_wr_in && (reg_addr_in > `RTD_REG_INT_CLEAR);

   // =======================================================
   // Descriptor address decode
   always_comb begin
      is_mc = (cmd_sa_reg == 5'h00) || (cmd_sa_reg == 5'h1F);
      if (is_mc && cmd_tx_reg) begin
         desc_addr = `RTD_TXMC_BASE + {5'h00, cmd_wc_reg, 2'b00};
      end else if (is_mc) begin
         desc_addr = `RTD_RXMC_BASE + {5'h00, cmd_wc_reg, 2'b00};
      end else begin
         desc_addr = `RTD_TXSA_BASE + {5'h00, cmd_sa_reg, 2'b00};
      end
      if (cmd_bcast_reg) begin
         sa_ptr = mem_q[desc_addr + `RTD_DESC_BCAST][`RTD_ADDR_W-1:0];
      end else begin
         sa_ptr = mem_q[desc_addr + `RTD_DESC_PTR][`RTD_ADDR_W-1:0];
      end
      word_cnt = (cmd_wc_reg == 5'h00) ? `RTD_MAX_DATA_WORDS : {1'b0, cmd_wc_reg};
   end

   // =======================================================
   // Host register port
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         cfg_reg <= `RTD_CFG_RESET;
         ien_reg <= '0;
      end else if (ce_in && reg_wr_in) begin
         if (reg_addr_in == `RTD_REG_MASTER_CFG) begin
            cfg_reg <= reg_wdata_in;
         end
         if (reg_addr_in == `RTD_REG_INT_ENABLE) begin
            ien_reg <= reg_wdata_in[`RTD_NUM_EVENTS-1:0];
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         rdata_reg <= '0;
      end else if (ce_in) begin
         if (!reg_rd_in) begin
            rdata_reg <= '0;
         end else begin
            case (reg_addr_in)
               `RTD_REG_MASTER_CFG: rdata_reg <= cfg_reg;
               `RTD_REG_INT_STATUS: rdata_reg <= {12'h000, status_w};
               `RTD_REG_INT_ENABLE: rdata_reg <= {12'h000, ien_reg};
               `RTD_REG_INT_CLEAR:  rdata_reg <= '0;
               default:             rdata_reg <= mem_q[reg_addr_in];
            endcase
         end
      end
   end

   assign clear_w = (reg_wr_in && (reg_addr_in == `RTD_REG_INT_CLEAR)) ?
                    reg_wdata_in[`RTD_NUM_EVENTS-1:0] : '0;

   // =======================================================
   // Shared memory, engine write lands last on a collision
   always_ff @(posedge core_clk_in) begin
      if (ce_in) begin
         if (host_mem_wr) begin
            mem_q[reg_addr_in] <= reg_wdata_in;
         end
         if (eng_we) begin
            mem_q[eng_addr] <= eng_wdata;
         end
      end
   end

   // =======================================================
   // Time tag counter
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         ttag_reg <= '0;
      end else if (ce_in) begin
         ttag_reg <= ttag_reg + 16'h0001;
      end
   end

   // =======================================================
   // Message sequencer
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         state_reg     <= RTD_IDLE;
         cmd_tx_reg    <= 1'b0;
         cmd_bcast_reg <= 1'b0;
         cmd_sa_reg    <= '0;
         cmd_wc_reg    <= '0;
         desc_reg      <= '0;
         buf_reg       <= '0;
         ptr_reg       <= '0;
         cnt_reg       <= '0;
         ctrl_reg      <= '0;
         index_reg     <= '0;
         tx_valid_reg  <= 1'b0;
         tx_data_reg   <= '0;
      end else if (ce_in) begin
         case (state_reg)
            RTD_IDLE: begin
               if (cmd_valid_in && started) begin
                  cmd_tx_reg    <= cmd_tx_in;
                  cmd_bcast_reg <= cmd_bcast_in;
                  cmd_sa_reg    <= cmd_sa_in;
                  cmd_wc_reg    <= cmd_wc_in;
                  state_reg     <= RTD_DESC;
               end
            end
            RTD_DESC: begin
               desc_reg <= desc_addr;
               ctrl_reg <= mem_q[desc_addr + `RTD_DESC_CTRL];
               cnt_reg  <= word_cnt;
               if (is_mc) begin
                  buf_reg   <= desc_addr + `RTD_DESC_PTR;
                  index_reg <= '0;
                  ptr_reg   <= desc_addr + `RTD_MC_DATA;
                  cnt_reg   <= 6'd1;
                  if (!cmd_wc_reg[4]) begin
                     state_reg <= RTD_MIW;
                  end else if (cmd_tx_reg) begin
                     state_reg <= RTD_TX;
                  end else begin
                     state_reg <= RTD_MC_RX;
                  end
               end else if (cmd_tx_reg) begin
                  buf_reg   <= sa_ptr;
                  ptr_reg   <= sa_ptr + `RTD_BUF_DATA_OFS;
                  index_reg <= mem_q[desc_addr + `RTD_DESC_INDEX];
                  // Broadcast words are absorbed, a terminal never answers one
                  state_reg <= cmd_bcast_reg ? RTD_RX : RTD_TX;
               end else begin
                  state_reg <= RTD_IDLE;
               end
            end
            RTD_TX: begin
               if (!tx_valid_reg || tx_ready_in) begin
                  if (cnt_reg != 6'd0) begin
                     tx_valid_reg <= 1'b1;
                     tx_data_reg  <= mem_q[ptr_reg];
                     ptr_reg      <= ptr_reg + 12'h001;
                     cnt_reg      <= cnt_reg - 6'd1;
                  end else begin
                     tx_valid_reg <= 1'b0;
                     state_reg    <= RTD_MIW;
                  end
               end
            end
            RTD_RX: begin
               if (rx_valid_in) begin
                  ptr_reg <= ptr_reg + 12'h001;
                  cnt_reg <= cnt_reg - 6'd1;
                  if (cnt_reg == 6'd1) begin
                     state_reg <= RTD_MIW;
                  end
               end
            end
            RTD_MC_RX: begin
               if (rx_valid_in) begin
                  state_reg <= RTD_MIW;
               end
            end
            RTD_MIW: begin
               state_reg <= RTD_TTW;
            end
            RTD_TTW: begin
               state_reg <= is_mc ? RTD_IDLE : RTD_INDEX;
            end
            RTD_INDEX: begin
               state_reg <= RTD_IDLE;
            end
            default: begin
               state_reg <= RTD_IDLE;
            end
         endcase
      end
   end

   // =======================================================
   // Engine memory writes
   always_comb begin
      eng_we    = 1'b0;
      eng_addr  = ptr_reg;
      eng_wdata = rx_data_in;
      case (state_reg)
         RTD_RX: begin
            eng_we = rx_valid_in;
         end
         RTD_MC_RX: begin
            eng_addr = desc_reg + `RTD_MC_DATA;
            eng_we   = rx_valid_in && simple_mc && (cmd_wc_reg == `RTD_MC_SYNC_DATA);
         end
         RTD_MIW: begin
            eng_we    = 1'b1;
            eng_addr  = buf_reg;
            eng_wdata = {cmd_bcast_reg, cmd_tx_reg, cmd_sa_reg, cmd_wc_reg, 4'h0};
         end
         RTD_TTW: begin
            eng_we    = 1'b1;
            eng_addr  = buf_reg + 12'h001;
            eng_wdata = ttag_reg;
         end
         RTD_INDEX: begin
            // Zero index keeps the same buffer for every message
            eng_we    = (index_reg != 16'h0000);
            eng_addr  = desc_reg + `RTD_DESC_INDEX;
            eng_wdata = index_reg - 16'h0001;
         end
         default: begin
            eng_we = 1'b0;
         end
      endcase
   end

   // =======================================================
   // Interrupt events
   always_comb begin
      event_w = '0;
      if (state_reg == RTD_TTW) begin
         event_w[`RTD_EV_ACCESSED] = ctrl_reg[`RTD_CTRL_IWA_BIT];
         event_w[`RTD_EV_SECOND]   = ctrl_reg[`RTD_CTRL_SEC_BIT];
      end
      event_w[`RTD_EV_INDEX_ZERO] = (state_reg == RTD_INDEX) && (index_reg == 16'h0001);
      event_w[`RTD_EV_IGNORED]    = (state_reg == RTD_IDLE) && cmd_valid_in && !started;
   end

   genvar gi;
   generate
      for (gi = 0; gi < `RTD_NUM_EVENTS; gi = gi + 1) begin : g_status
         rtd_sticky_bit u_flag (
            .core_clk_in (core_clk_in),
            .resetn_in   (resetn_in),
            .ce_in       (ce_in),
            .set_in      (event_w[gi]),
            .clr_in      (clear_w[gi]),
            .flag_out    (status_w[gi])
         );
      end
   endgenerate

   // =======================================================
   // Outputs
   assign reg_rdata_out = rdata_reg;
   assign cmd_ready_out = (state_reg == RTD_IDLE);
   assign rx_ready_out  = (state_reg == RTD_RX) || (state_reg == RTD_MC_RX);
   assign tx_valid_out  = tx_valid_reg;
   assign tx_data_out   = tx_data_reg;
   assign busy_out      = (state_reg != RTD_IDLE);
   assign running_out   = started;
   assign irq_out       = |(status_w & ien_reg);

endmodule // rtd_desc_engine

// file: sim/rtd_bc_model.sv
`timescale 1ns/100ps

// ==========
// Bus controller data side: takes transmit words, feeds receive words
module rtd_bc_model (
   input  wire logic        clk_in,
   input  wire logic        stall_in,
   input  wire logic        tx_valid_in,
   output logic             tx_ready_out,
   input  wire logic [15:0] tx_data_in,
   input  wire logic        rx_ready_in,
   output logic             rx_valid_out,
   output logic [15:0]      rx_data_out
);
   logic [15:0] got [$];
   logic [15:0] feed [$];
   logic        take;

   initial begin
      tx_ready_out = 1'b0;
      rx_valid_out = 1'b0;
      rx_data_out  = 16'h0000;
   end

   // An offered word is held until taken; an idle line shows a changing value
   always @(posedge clk_in) begin
      take = rx_valid_out && rx_ready_in;
      if (take)
         void'(feed.pop_front());
      if (tx_valid_in && tx_ready_out)
         got.push_back(tx_data_in);
      tx_ready_out <= !stall_in;
      if (!rx_valid_out || take) begin
         rx_valid_out <= feed.size() != 0 && !stall_in;
         rx_data_out  <= (feed.size() != 0 && !stall_in) ? feed[0] : ~rx_data_out;
      end
   end
endmodule // rtd_bc_model

// file: sim/rtd_desc_engine_properties.sv
`timescale 1ns/100ps
`include "rtd_defs.svh"

// ==========
// Port checks of the descriptor engine
module rtd_desc_engine_properties (
   input wire logic        core_clk_in,
   input wire logic        resetn_in,
   input wire logic [11:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic        reg_wr_in,
   input wire logic        reg_rd_in,
   input wire logic [15:0] reg_rdata_out,
   input wire logic        cmd_valid_in,
   input wire logic        cmd_ready_out,
   input wire logic        cmd_tx_in,
   input wire logic        cmd_bcast_in,
   input wire logic [4:0]  cmd_sa_in,
   input wire logic [4:0]  cmd_wc_in,
   input wire logic        rx_ready_out,
   input wire logic        tx_valid_out,
   input wire logic        tx_ready_in,
   input wire logic [15:0] tx_data_out,
   input wire logic        busy_out,
   input wire logic        running_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!resetn_in);

   sequence s_take;
      cmd_valid_in && cmd_ready_out && running_out;
   endsequence
   sequence s_tx_sa;
      s_take ##0 (cmd_tx_in && !cmd_bcast_in && cmd_sa_in inside {[1:30]});
   endsequence
   sequence s_rx_sa;
      s_take ##0 (!cmd_tx_in && cmd_sa_in inside {[1:30]});
   endsequence
   sequence s_rx_mc;
      s_take ##0 (!cmd_tx_in && cmd_sa_in inside {0, 31} && cmd_wc_in[4]);
   endsequence

   chk_read_pulse: assert property (
      !$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
      else $error("read data outside its cycle");
   chk_cfg_start: assert property (
      reg_wr_in && reg_addr_in == `RTD_REG_MASTER_CFG
      |=> running_out == $past(reg_wdata_in[`RTD_CFG_START_BIT]))
      else $error("start bit not taken from write");
   chk_idle_gate: assert property (
      cmd_valid_in && cmd_ready_out && !running_out |=> !busy_out)
      else $error("command taken while stopped");
   chk_take_busy: assert property (
      s_take |=> busy_out && !cmd_ready_out) else $error("taken command left engine idle");
   chk_tx_first: assert property (
      s_tx_sa |-> ##3 tx_valid_out) else $error("first transmit word late");
   chk_tx_hold: assert property (
      tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out))
      else $error("transmit word dropped before accepted");
   chk_rx_drop: assert property (
      s_rx_sa |=> (!rx_ready_out && !tx_valid_out) [*2] ##[0:1] !busy_out)
      else $error("receive subaddress not dropped");
   chk_mc_data: assert property (
      s_rx_mc |-> ##2 rx_ready_out) else $error("mode data word not requested");
   chk_busy_bound: assert property (
      $rose(busy_out) |-> ##[1:400] !busy_out) else $error("engine stuck busy");
endmodule // rtd_desc_engine_properties

bind rtd_desc_engine rtd_desc_engine_properties u_chk (.core_clk_in, .resetn_in,
   .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .cmd_valid_in,
   .cmd_ready_out, .cmd_tx_in, .cmd_bcast_in, .cmd_sa_in, .cmd_wc_in, .rx_ready_out,
   .tx_valid_out, .tx_ready_in, .tx_data_out, .busy_out, .running_out);

// file: sim/rtd_desc_engine_tb.sv
`timescale 1ns/100ps
`include "rtd_defs.svh"

// ==========
// Self-checking bench of the descriptor engine
module rtd_desc_engine_tb;
   logic        clk    = 1'b0;
   logic        resetn = 1'b0;
   logic [11:0] addr   = 12'h000;
   logic [15:0] wdata  = 16'h0000;
   logic        wr     = 1'b0;
   logic        rd     = 1'b0;
   logic        ce     = 1'b1;
   logic        cv     = 1'b0;
   logic        ctx    = 1'b0;
   logic        cbc    = 1'b0;
   logic [4:0]  csa    = 5'h00;
   logic [4:0]  cwc    = 5'h00;
   logic [15:0] rnd    = 16'h0010;
   logic [15:0] srnd   = 16'h0010;
   logic [15:0] rdata, txd, rxd, v0, v1;
   logic        cready, rxv, rxr, txv, txr, busy, run, irq;
   logic [4:0]  wc;
   logic [15:0] mem [4096];
   logic [15:0] sa1 [4]  = '{16'h0800, 16'h0822, 16'h0000, 16'h0800};
   logic [15:0] sa30 [4] = '{16'h0000, 16'h0844, 16'h0000, 16'h0800};
   int          bad_count = 0;
   int          total_checks = 0;

   rtd_desc_engine dut (
      .core_clk_in(clk), .resetn_in(resetn), .ce_in(ce),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdata), .cmd_valid_in(cv), .cmd_ready_out(cready),
      .cmd_tx_in(ctx), .cmd_bcast_in(cbc), .cmd_sa_in(csa), .cmd_wc_in(cwc),
      .rx_valid_in(rxv), .rx_ready_out(rxr), .rx_data_in(rxd),
      .tx_valid_out(txv), .tx_ready_in(txr), .tx_data_out(txd),
      .busy_out(busy), .running_out(run), .irq_out(irq));
   rtd_bc_model bc (
      .clk_in(clk), .stall_in(srnd[0]), .tx_valid_in(txv), .tx_ready_out(txr),
      .tx_data_in(txd), .rx_ready_in(rxr), .rx_valid_out(rxv), .rx_data_out(rxd));

   function automatic logic [15:0] lfsr_step(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function automatic logic [15:0] next_rnd();
      rnd = lfsr_step(rnd);
      return rnd;
   endfunction
   function automatic logic [15:0] message_info_word(input logic b, t, input logic [4:0] s, w);
      return {b, t, s, w, 4'h0};
   endfunction

   always #25 clk = ~clk;
   always @(posedge clk) srnd <= lfsr_step(srnd);

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic wreg(input logic [11:0] a, input logic [15:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      mem[a] = d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [11:0] a, input logic [15:0] exp);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      check(rdata, exp);
   endtask
   task automatic cmd(input logic t, b, input logic [4:0] s, w);
      int n;
      @(posedge clk);
      ctx <= t;
      cbc <= b;
      csa <= s;
      cwc <= w;
      cv  <= 1'b1;
      @(posedge clk);
      cv <= 1'b0;
      @(negedge clk);
      for (n = 0; n < 500 && busy !== 1'b0; n++) @(negedge clk);
      if (n == 500) bad_count++;
   endtask
   task automatic txchk(input logic [4:0] s, w, input logic [11:0] base);
      bc.got.delete();
      cmd(1'b1, 1'b0, s, w);
      check(16'(bc.got.size()), w == 5'd0 ? 16'h0020 : {11'h000, w});
      foreach (bc.got[k]) check(bc.got[k], mem[base + 12'(k)]);
   endtask
   task automatic close_out();
      $display("checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      #1_000_000;
      bad_count++;
      close_out();
   end

   initial begin
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      rreg(`RTD_REG_MASTER_CFG, `RTD_CFG_RESET);
      cmd(1'b1, 1'b0, 5'd1, 5'd1);
      check(16'(bc.got.size()), 16'h0000);
      rreg(`RTD_REG_INT_STATUS, 16'h0008);
      wreg(`RTD_REG_INT_CLEAR, 16'h000F);
      rreg(`RTD_REG_INT_CLEAR, 16'h0000);
      rreg(`RTD_REG_INT_STATUS, 16'h0000);
      for (int a = 12'h480; a < 12'h900; a++) wreg(12'(a), 16'h0000);
      foreach (sa1[i]) wreg(12'h484 + 12'(i), sa1[i]);
      foreach (sa30[i]) wreg(12'h4F8 + 12'(i), sa30[i]);
      wreg(12'h544, 16'h6000);
      wreg(12'h584, 16'h6000);
      for (int i = 0; i < 32; i++) begin
         wreg(12'h824 + 12'(i), next_rnd());
         wreg(12'h846 + 12'(i), next_rnd());
      end
      wreg(12'h5C3, next_rnd());
      wreg(`RTD_REG_INT_ENABLE, 16'h0003);
      wreg(`RTD_REG_MASTER_CFG, 16'h0058);
      rreg(`RTD_REG_MASTER_CFG, 16'h0058);
      check({15'h0000, run}, 16'h0001);
      for (int i = 0; i < 6; i++) begin
         wc = i == 0 ? 5'd0 : i == 1 ? 5'd31 : i == 5 ? 5'd3 : 5'(next_rnd());
         txchk(5'd1, wc, 12'h824);
      end
      rreg(12'h822, message_info_word(1'b0, 1'b1, 5'd1, 5'd3));
      rreg(12'h486, 16'h0000);
      rreg(`RTD_REG_INT_STATUS, 16'h0000);
      txchk(5'd30, 5'd4, 12'h846);
      wreg(12'h4FA, 16'h0001);
      txchk(5'd30, 5'd1, 12'h846);
      rreg(12'h4FA, 16'h0000);
      rreg(`RTD_REG_INT_STATUS, 16'h0004);
      wreg(`RTD_REG_INT_CLEAR, 16'h0004);
      v0 = next_rnd();
      v1 = next_rnd();
      bc.feed.push_back(v0);
      bc.feed.push_back(v1);
      cmd(1'b1, 1'b1, 5'd1, 5'd2);
      rreg(12'h802, v0);
      rreg(12'h803, v1);
      rreg(12'h824, mem[12'h824]);
      v0 = next_rnd();
      bc.feed.push_back(v0);
      cmd(1'b0, 1'b0, 5'd31, 5'd17);
      rreg(12'h547, v0);
      rreg(`RTD_REG_INT_STATUS, 16'h0003);
      check({15'h0000, irq}, 16'h0001);
      wreg(`RTD_REG_INT_ENABLE, 16'h0000);
      @(negedge clk);
      check({15'h0000, irq}, 16'h0000);
      wreg(`RTD_REG_INT_CLEAR, 16'h0003);
      wreg(`RTD_REG_INT_ENABLE, 16'h0003);
      cmd(1'b1, 1'b0, 5'd0, 5'd2);
      rreg(`RTD_REG_INT_STATUS, 16'h0000);
      cmd(1'b1, 1'b0, 5'd0, 5'd1);
      rreg(`RTD_REG_INT_STATUS, 16'h0003);
      bc.got.delete();
      cmd(1'b1, 1'b0, 5'd0, 5'd16);
      check(bc.got[0], mem[12'h5C3]);
      wreg(`RTD_REG_MASTER_CFG, 16'h0050);
      bc.feed.push_back(~v0);
      cmd(1'b0, 1'b0, 5'd31, 5'd17);
      rreg(12'h547, v0);
      check(16'(bc.feed.size()), 16'h0000);
      @(posedge clk);
      ce <= 1'b0;
      wreg(`RTD_REG_INT_ENABLE, 16'h0000);
      ce <= 1'b1;
      rreg(`RTD_REG_INT_ENABLE, 16'h0003);
      bc.feed.push_back(v1);
      cmd(1'b0, 1'b0, 5'd7, 5'd2);
      check({15'h0000, busy}, 16'h0000);
      check(16'(bc.feed.size()), 16'h0001);
      close_out();
   end
endmodule // rtd_desc_engine_tb
